// File: hw/asc_pkg.sv
package asc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ASC_OFF_CONTROL = 4'h0;
	localparam logic [3:0] ASC_OFF_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ASC_OFF_IRQ_MASK = 4'h8;
	localparam logic [3:0] ASC_OFF_SEQ_COUNT = 4'hC;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int ASC_POS_REF = 13;
	localparam int ASC_POS_CAL = 12;
	localparam int ASC_POS_SCAN = 10;
	localparam int ASC_POS_FILL = 7;
	localparam int ASC_POS_SPI = 2;
	localparam int ASC_POS_SPLIT = 1;
	localparam int ASC_POS_ALT = 0;

	// ****************************************
	// reset values and encodings
	// ****************************************
	localparam logic [2:0] ASC_REF_RESET = 3'h0;
	localparam logic [3:0] ASC_SPI_RESET = 4'h0;
	localparam logic [3:0] ASC_HALF_WORDS = 4'h8;
	localparam logic [1:0] ASC_IRQ_RESET = 2'h0;
	localparam int ASC_IRQ_SEQ = 0;
	localparam int ASC_IRQ_GROUP = 1;

	typedef enum logic [1:0] {
		ASC_MUX_A,
		ASC_MUX_B
	} asc_mux_t;

	// analog side control bundle
	typedef struct packed {
		logic vref_high_ext;
		logic vref_low_ext;
		logic cal_short;
		logic scan_en;
		asc_mux_t mux_sel;
		logic [3:0] write_addr;
	} asc_analog_t;

	// bus request bundle
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} asc_bus_t;

endpackage

// File: hw/asc_seq_counter.sv
`timescale 1ns/1ps
module asc_seq_counter (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic clear,
	input wire logic step,
	input wire logic [3:0] limit,
	// status
	output logic [3:0] count,
	output logic wrap
);
	import asc_pkg::*;

	typedef struct packed {
		logic [3:0] count;
		logic wrap;
	} asc_cnt_state_t;

	asc_cnt_state_t state;
	asc_cnt_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.wrap = 1'b0;
		if (clear) begin
			next_state.count = 4'h0;
		end else if (step) begin
			if (state.count >= limit) begin
				next_state.count = 4'h0;
				next_state.wrap = 1'b1;
			end else begin
				next_state.count = state.count + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign count = state.count;
	assign wrap = state.wrap;
endmodule

// File: hw/asc_top.sv
`timescale 1ns/1ps
module asc_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire asc_pkg::asc_bus_t bus,
	output logic [31:0] rdata,
	// converter core events
	input wire logic sample_done,
	input wire logic seq_done,
	// analog side control
	output asc_pkg::asc_analog_t analog,
	// interrupt
	output logic irq
);
	import asc_pkg::*;

	typedef struct packed {
		logic [2:0] ref_sel;
		logic cal;
		logic scan;
		logic fill;
		logic [3:0] spi;
		logic split;
		logic alt;
		logic alt_phase;
		logic [3:0] waddr;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
		asc_analog_t analog;
		logic irq;
	} asc_state_t;

	asc_state_t state;
	asc_state_t next_state;
	logic [3:0] seq_count;
	logic group_wrap;
	logic ctrl_write;

	assign ctrl_write = bus.wr && (bus.addr == ASC_OFF_CONTROL);

	// ****************************************
	// sequence counter
	// ****************************************
	// restart the count on every control write so a group never overruns
	asc_seq_counter u_count (
		.clk(clk),
		.arst_n(arst_n),
		.clear(ctrl_write),
		.step(seq_done),
		.limit(state.spi),
		.count(seq_count),
		.wrap(group_wrap)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] ctrl_word;
		logic [1:0] events;
		ctrl_word = 32'h0;
		events = 2'h0;
		next_state = state;

		// only implemented bits fill the word
		ctrl_word[ASC_POS_REF +: 3] = state.ref_sel;
		ctrl_word[ASC_POS_CAL] = state.cal;
		ctrl_word[ASC_POS_SCAN] = state.scan;
		ctrl_word[ASC_POS_FILL] = state.fill;
		ctrl_word[ASC_POS_SPI +: 4] = state.spi;
		ctrl_word[ASC_POS_SPLIT] = state.split;
		ctrl_word[ASC_POS_ALT] = state.alt;

		if (ctrl_write) begin
			next_state.ref_sel = bus.wdata[ASC_POS_REF +: 3];
			next_state.cal = bus.wdata[ASC_POS_CAL];
			next_state.scan = bus.wdata[ASC_POS_SCAN];
			next_state.spi = bus.wdata[ASC_POS_SPI +: 4];
			next_state.split = bus.wdata[ASC_POS_SPLIT];
			next_state.alt = bus.wdata[ASC_POS_ALT];
			// reconfiguring restarts the store and mux pattern
			next_state.waddr = 4'h0;
			next_state.fill = 1'b0;
			next_state.alt_phase = 1'b0;
		end else begin
			if (sample_done) begin
				// alternate B and A after first A
				next_state.alt_phase = state.alt ? ~state.alt_phase : 1'b0;
				// wrap inside the half or the whole store
				if (state.split) begin
					next_state.waddr = {state.waddr[3], state.waddr[2:0] + 3'h1};
				end else begin
					next_state.waddr = state.waddr + 4'h1;
				end
			end
			if (group_wrap) begin
				// at each group wrap swap halves when split, else restart the store at word 0
				if (state.split) begin
					next_state.fill = ~state.fill;
					next_state.waddr = state.fill ? 4'h0 : ASC_HALF_WORDS;
				end else begin
					next_state.waddr = 4'h0;
				end
				next_state.alt_phase = 1'b0;
			end
		end

		events[ASC_IRQ_SEQ] = seq_done;
		events[ASC_IRQ_GROUP] = group_wrap;

		if (bus.wr && (bus.addr == ASC_OFF_IRQ_MASK)) begin
			next_state.irq_mask = bus.wdata[1:0];
		end

		next_state.rdata = 32'h0;
		if (bus.rd) begin
			unique case (bus.addr)
				ASC_OFF_CONTROL: next_state.rdata = ctrl_word;
				ASC_OFF_IRQ_STATUS: next_state.rdata = {30'h0, state.irq_status};
				ASC_OFF_IRQ_MASK: next_state.rdata = {30'h0, state.irq_mask};
				ASC_OFF_SEQ_COUNT: next_state.rdata = {28'h0, seq_count};
				default: next_state.rdata = 32'h0;
			endcase
		end

		// read clears the status, but a new event wins
		if (bus.rd && (bus.addr == ASC_OFF_IRQ_STATUS)) begin
			next_state.irq_status = events;
		end else begin
			next_state.irq_status = state.irq_status | events;
		end
		next_state.irq = |(next_state.irq_status & next_state.irq_mask);

		// externals only for codes 001, 010, 011
		next_state.analog.vref_high_ext = ~next_state.ref_sel[2] & next_state.ref_sel[0];
		next_state.analog.vref_low_ext = ~next_state.ref_sel[2] & next_state.ref_sel[1];
		// calibration shorts amplifier to low reference
		next_state.analog.cal_short = next_state.cal;
		next_state.analog.scan_en = next_state.scan & ~next_state.cal;
		next_state.analog.mux_sel = next_state.alt_phase ? ASC_MUX_B : ASC_MUX_A;
		// top bit of waddr picks the half under write
		next_state.analog.write_addr = next_state.waddr;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
			state.ref_sel <= ASC_REF_RESET;
			state.spi <= ASC_SPI_RESET;
			state.irq_status <= ASC_IRQ_RESET;
			state.irq_mask <= ASC_IRQ_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign rdata = state.rdata;
	assign analog = state.analog;
	assign irq = state.irq;
endmodule

// File: verif/asc_props.sv
`timescale 1ns/1ps
module asc_props (
	// watched ports
	input wire logic clk,
	input wire logic arst_n,
	input wire asc_pkg::asc_bus_t bus,
	input wire logic [31:0] rdata,
	input wire logic sample_done,
	input wire logic seq_done,
	input wire asc_pkg::asc_analog_t analog,
	input wire logic irq
);
	import asc_pkg::*;
	logic w0;
	assign w0 = bus.wr && bus.addr == ASC_OFF_CONTROL;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_rdata_idle:
		assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("read data outside slot");
	chk_unused_zero:
		assert property ($past(bus.rd && bus.addr == ASC_OFF_CONTROL) |-> (rdata & 32'hFFFF0B40) == 32'h0)
		else $error("unused control bit set");
	chk_ref_decode:
		assert property (w0 |=> analog.vref_high_ext == ($past(bus.wdata[13]) && !$past(bus.wdata[15]))
			&& analog.vref_low_ext == ($past(bus.wdata[14]) && !$past(bus.wdata[15]))) else $error("bad reference");
	chk_cal_tie:
		assert property (w0 |=> analog.cal_short == $past(bus.wdata[12])) else $error("bad calibration");
	chk_scan_follow:
		assert property (w0 |=> analog.scan_en == ($past(bus.wdata[10]) && !$past(bus.wdata[12])))
		else $error("bad scan enable");
	chk_mux_restart:
		assert property (w0 |=> analog.mux_sel == ASC_MUX_A && analog.write_addr == 4'h0) else $error("no restart");
	chk_fill_ro:
		assert property (w0 && !seq_done ##1 !seq_done ##1 bus.rd && bus.addr == ASC_OFF_CONTROL |=> rdata[7] == 1'b0)
		else $error("fill bit written");
	chk_irq_cause:
		assert property ($rose(irq) |-> $past(seq_done) || $past(seq_done, 2) || $past(seq_done, 3)
			|| $past(bus.wr) || $past(bus.wr, 2)) else $error("irq without cause");
	chk_irq_clear:
		assert property ($fell(irq) |-> $past(bus.rd) || $past(bus.rd, 2) || $past(bus.wr) || $past(bus.wr, 2))
		else $error("irq dropped alone");
endmodule
bind asc_top asc_props props (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
	.sample_done(sample_done), .seq_done(seq_done), .analog(analog), .irq(irq));

// File: verif/asc_core_model.sv
`timescale 1ns/1ps
module asc_core_model (
	// converter core events
	input wire logic clk,
	output logic sample_done,
	output logic seq_done
);
	initial begin
		sample_done = 1'b0;
		seq_done = 1'b0;
	end
	// one sample per sequence; spare cycle lets the result land
	task run(input int n);
		repeat (n) begin
			sample_done <= 1'b1;
			@(posedge clk);
			sample_done <= 1'b0;
			seq_done <= 1'b1;
			@(posedge clk);
			seq_done <= 1'b0;
			@(posedge clk);
		end
	endtask
endmodule

// File: verif/asc_top_tb.sv
`timescale 1ns/1ps
module asc_top_tb;
	import asc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	asc_bus_t bus = '0;
	logic [31:0] rdata;
	logic sample_done;
	logic seq_done;
	logic irq;
	asc_analog_t analog;
	logic rd_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h4A73E3C7;
	logic [31:0] w;
	int sv[3] = '{0, 1, 15};
	int failures = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	asc_top dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .sample_done(sample_done),
		.seq_done(seq_done), .analog(analog), .irq(irq));
	asc_core_model core (.clk(clk), .sample_done(sample_done), .seq_done(seq_done));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, want, seen);
		end
	endtask
	task end_sim;
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// idle cycle after each strobe keeps one assignment per step
	task op(input logic r, input logic [3:0] a, input logic [31:0] d);
		if (r) exp_q.push_back(d);
		bus <= '{addr: a, wdata: d, wr: !r, rd: r};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task wirq(input logic e);
		int n;
		n = 0;
		while (irq !== e && n < 5) begin
			@(posedge clk);
			n++;
		end
		chk(irq, e, "irq");
		// a wait that ran out ends the run here
		if (irq !== e) begin
			end_sim();
		end
	endtask
	always @(posedge clk) begin
		if (rd_d) chk(rdata, exp_q.pop_front(), "read data");
		rd_d <= bus.rd;
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		op(1, ASC_OFF_CONTROL, 32'h0);
		op(1, ASC_OFF_IRQ_STATUS, 32'h0);
		op(1, 4'h2, 32'h0);
		for (int i = 0; i < 8; i++) begin
			w = rnd();
			w[15:13] = 3'(i);
			op(0, ASC_OFF_CONTROL, w);
			op(1, ASC_OFF_CONTROL, w & 32'h0000F43F);
			chk(analog, {w[13] && !w[15], w[14] && !w[15], w[12], w[10] && !w[12], ASC_MUX_A, 4'h0}, "analog");
		end
		op(0, ASC_OFF_IRQ_MASK, 32'h2);
		for (int k = 0; k < 3; k++) begin
			op(0, ASC_OFF_CONTROL, (sv[k] << 2) | 32'h2);
			core.run(sv[k]);
			wirq(1'b0);
			core.run(1);
			wirq(1'b1);
			chk(analog.write_addr, 4'h8, "write half");
			op(1, ASC_OFF_CONTROL, (sv[k] << 2) | 32'h82);
			op(1, ASC_OFF_IRQ_STATUS, 32'h3);
			wirq(1'b0);
			// second group flips back to the low half
			core.run(sv[k] + 1);
			wirq(1'b1);
			chk(analog.write_addr, 4'h0, "low half");
			op(1, ASC_OFF_CONTROL, (sv[k] << 2) | 32'h2);
			op(1, ASC_OFF_IRQ_STATUS, 32'h3);
			wirq(1'b0);
		end
		op(0, ASC_OFF_CONTROL, 32'hD);
		for (int k = 1; k < 4; k++) begin
			core.run(1);
			chk(analog, {4'h0, k[0] ? ASC_MUX_B : ASC_MUX_A, 4'(k)}, "alternate");
		end
		op(1, ASC_OFF_SEQ_COUNT, 32'h3);
		op(1, ASC_OFF_IRQ_MASK, 32'h2);
		op(0, ASC_OFF_IRQ_MASK, 32'h1);
		wirq(1'b1);
		op(1, ASC_OFF_IRQ_STATUS, 32'h1);
		wirq(1'b0);
		// mid-run reset must clear everything software set
		op(0, ASC_OFF_CONTROL, 32'hFFFF);
		op(0, ASC_OFF_IRQ_MASK, 32'h3);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(analog, 32'h0, "analog after reset");
		chk(irq, 1'b0, "irq after reset");
		op(1, ASC_OFF_CONTROL, 32'h0);
		op(1, ASC_OFF_IRQ_MASK, 32'h0);
		op(1, ASC_OFF_IRQ_STATUS, 32'h0);
		// let the last read be compared before the verdict
		@(posedge clk);
		chk(exp_q.size(), 32'h0, "pending reads");
		end_sim();
	end
endmodule
